// *** include/mmot_pkg.sv ***
// Constants, modes and state type of the multi-mode output timer.
// Assumes one 125 MHz clock; pins arrive unsynchronised.
package mmot_pkg;
    // ----------------------------------------
    // Widths and timing
    // ----------------------------------------
    localparam int COUNT_W = 20;
    localparam int DUTY_W = 7;
    localparam int SHOT_W = 14;
    localparam int CLK_MHZ = 125;
    localparam int SHOT_STEP_MS = 10;
    localparam int SHOT_TICK_CYCLES = SHOT_STEP_MS * CLK_MHZ * 1000;
    localparam int RESET_HOLD_TIME_MS = 500;
    localparam int DUTY_FULL = 100;
    localparam int DUTY_HALF = 50;

    // ----------------------------------------
    // Output modes
    // ----------------------------------------
    typedef enum logic [3:0] {
        MD_ONDLY1, MD_ONDLY2, MD_PWRON1, MD_PWRON2,
        MD_SHOTFLK, MD_ONOFF1, MD_OFFDLY1, MD_INTERVAL,
        MD_ACCUM, MD_ONOFF2, MD_OFFDLY2, MD_DUTYFLK,
        MD_STOPWATCH
    } mmot_mode_t;

    // ----------------------------------------
    // Block state
    // ----------------------------------------
    typedef struct packed {
        logic [2:0] stSync;
        logic [2:0] rsSync;
        logic [2:0] gtSync;
        logic stF;
        logic rsF;
        logic gtF;
        logic stPrev;
        logic running;
        logic done;
        logic out;
        logic phase;
        logic swRun;
        logic shotOn;
        logic tick;
        logic [31:0] div;
        logic [31:0] shotDiv;
        logic [SHOT_W-1:0] shot;
        logic [COUNT_W-1:0] cnt;
        logic [COUNT_W-1:0] disp;
    } mmot_state_t;

    localparam mmot_state_t STATE_RESET = '0;
endpackage : mmot_pkg

// *** hdl/mmot_timer.sv ***
// Multi-mode output timer: start/reset/gate pins drive one control output.
// Assumes config ports are static or change slowly; pins are asynchronous.
//
// Contract
// - Duty flicker ON time is cycle times duty over 100, rounded to tick.
// - Changing only duty reshapes cyclic control with a fixed cycle time.
// - On-delay, one-shot flicker, duty flicker ignore start while timing.
// - Rising start begins timing; held start at reset release also begins.
// - On-delay two clears count and output when start drops.
// - Power-on delays start at reset release; start acts as a gate.
// - Power-on delay two keeps its count over power cycle; one clears.
// - Zero set value gives immediate output in on-delay and power-on delay modes.
// - Output is sustained until reset, or a one-shot pulse of set length.
// - One-shot flicker asserts at time-up, then clears after one period.
// - On/off delay, interval, off-delay keep reacting to start while timing.
// - Interval returns to reset state at time-up; on/off delay clears count, output takes start.
// - On/off delay one, interval, off-delay two: zero keeps output off.
// - Off-delay one: output on with start, off-delay timed after it drops.
// - Off-delay one and on/off delay two: zero makes output follow start.
// - Interval: start begins timing, output on during the interval.
// - Accumulative: counts only while start on, keeps count, sustained out.
// - Off-delay two holds output off while start is on.
// - Duty flicker starts on and inverts at each ON or OFF expiry.
// - Stopwatch: start presses alternately start and stop timing.
// - Stopwatch: reset/gate freezes display while running, clears if stopped.
`timescale 1ns/1ns
module mmot_timer
    import mmot_pkg::*;
#(
    parameter int SHOT_TICK_CYC = SHOT_TICK_CYCLES
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic startIn,
    input wire logic resetIn,
    input wire logic gateIn,
    input wire mmot_mode_t mode,
    input wire logic [COUNT_W-1:0] setValue,
    input wire logic [COUNT_W-1:0] cycleTime,
    input wire logic [DUTY_W-1:0] dutyPct,
    input wire logic oneShot,
    input wire logic [SHOT_W-1:0] shotTime,
    input wire logic [31:0] tickCycles,
    output logic ctlOut,
    output logic [COUNT_W-1:0] presentValue,
    output logic [COUNT_W-1:0] displayValue,
    output logic timingActive
);
    mmot_state_t s_r, s_nxt, rstVal;
    logic stRise, stFall, stEdge, shotTick, expired, swClr, latchMode, shotEn;
    logic [COUNT_W-1:0] cntInc, target, onTime;
    logic [COUNT_W+DUTY_W-1:0] prod;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.stSync = {s_r.stSync[1:0], startIn};
        s_nxt.rsSync = {s_r.rsSync[1:0], resetIn};
        s_nxt.gtSync = {s_r.gtSync[1:0], gateIn};
        s_nxt.stF = (s_r.stSync[1] == s_r.stSync[2]) ? s_r.stSync[2] : s_r.stF;
        s_nxt.rsF = (s_r.rsSync[1] == s_r.rsSync[2]) ? s_r.rsSync[2] : s_r.rsF;
        s_nxt.gtF = (s_r.gtSync[1] == s_r.gtSync[2]) ? s_r.gtSync[2] : s_r.gtF;
        s_nxt.stPrev = s_r.stF;
        stRise = s_r.stF & ~s_r.stPrev;
        stFall = ~s_r.stF & s_r.stPrev;
        stEdge = stRise | stFall;

        s_nxt.tick = s_r.div + 32'h1 >= tickCycles;
        s_nxt.div = s_nxt.tick ? '0 : s_r.div + 32'h1;
        shotTick = s_r.shotDiv + 32'h1 >= 32'(SHOT_TICK_CYC);
        s_nxt.shotDiv = shotTick ? '0 : s_r.shotDiv + 32'h1;
        prod = (COUNT_W + DUTY_W)'(cycleTime) * (COUNT_W + DUTY_W)'(dutyPct) + (COUNT_W + DUTY_W)'(DUTY_HALF);
        onTime = COUNT_W'(prod / (COUNT_W + DUTY_W)'(DUTY_FULL));
        target = setValue;
        if (mode == MD_DUTYFLK) begin
            target = s_r.phase ? (cycleTime - onTime) : onTime;
        end
        cntInc = s_r.cnt + COUNT_W'(1);
        expired = cntInc >= target;
        swClr = 1'b0;
        latchMode = 1'b0;

        unique case (mode)
            MD_ONDLY1, MD_ONDLY2: begin
                latchMode = 1'b1;
                if (stRise && !s_r.running && !s_r.done) begin
                    if (setValue == '0) begin
                        s_nxt.done = 1'b1;
                    end else begin
                        s_nxt.running = 1'b1;
                        s_nxt.cnt = '0;
                    end
                end else if (s_r.running && s_r.tick && !s_r.gtF) begin
                    s_nxt.cnt = cntInc;
                    if (expired) begin
                        s_nxt.running = 1'b0;
                        s_nxt.done = 1'b1;
                    end
                end
                if (mode == MD_ONDLY2 && !s_r.stF) begin
                    s_nxt.running = 1'b0;
                    s_nxt.done = 1'b0;
                    s_nxt.cnt = '0;
                end
            end
            MD_PWRON1, MD_PWRON2: begin
                latchMode = 1'b1;
                s_nxt.running = !s_r.done;
                if (!s_r.done) begin
                    if (setValue == '0) begin
                        s_nxt.done = 1'b1;
                    end else if (s_r.tick && !s_r.stF && !s_r.gtF) begin
                        s_nxt.cnt = cntInc;
                        s_nxt.done = expired;
                    end
                end
            end
            MD_SHOTFLK: begin
                if (stRise && !s_r.running) begin
                    s_nxt.running = 1'b1;
                    s_nxt.phase = 1'b0;
                    s_nxt.cnt = '0;
                end else if (s_r.running && s_r.tick && !s_r.gtF) begin
                    s_nxt.cnt = cntInc;
                    // on at time-up, off one period later
                    if (expired) begin
                        s_nxt.cnt = '0;
                        s_nxt.phase = !s_r.phase;
                        s_nxt.running = !s_r.phase;
                    end
                end
                s_nxt.out = s_nxt.running & s_nxt.phase;
            end
            MD_ONOFF1, MD_ONOFF2: begin
                if (stEdge) begin
                    s_nxt.running = 1'b1;
                    s_nxt.cnt = '0;
                end else if (s_r.running && s_r.tick && !s_r.gtF) begin
                    s_nxt.cnt = cntInc;
                    if (expired) begin
                        s_nxt.running = 1'b0;
                        s_nxt.out = s_r.stF;
                        s_nxt.cnt = '0;
                    end
                end
                if (setValue == '0) begin
                    s_nxt.running = 1'b0;
                    s_nxt.out = (mode == MD_ONOFF2) & s_r.stF;
                end
            end
            MD_OFFDLY1: begin
                // on with start, delay after drop
                if (s_r.stF) begin
                    s_nxt.out = 1'b1;
                    s_nxt.running = 1'b0;
                    s_nxt.cnt = '0;
                end else if (stFall) begin
                    s_nxt.running = 1'b1;
                end else if (s_r.running && s_r.tick && !s_r.gtF) begin
                    s_nxt.cnt = cntInc;
                    if (expired) begin
                        s_nxt.running = 1'b0;
                        s_nxt.out = 1'b0;
                        s_nxt.cnt = '0;
                    end
                end
                if (setValue == '0) begin
                    s_nxt.running = 1'b0;
                    s_nxt.out = s_r.stF;
                end
            end
            MD_INTERVAL: begin
                if (stRise) begin
                    s_nxt.running = 1'b1;
                    s_nxt.out = 1'b1;
                    s_nxt.cnt = '0;
                end else if (s_r.running && s_r.tick && !s_r.gtF) begin
                    s_nxt.cnt = cntInc;
                    if (expired) begin
                        s_nxt.running = 1'b0;
                        s_nxt.out = 1'b0;
                        s_nxt.cnt = '0;
                    end
                end
                if (setValue == '0) begin
                    s_nxt.running = 1'b0;
                    s_nxt.out = 1'b0;
                end
            end
            MD_ACCUM: begin
                s_nxt.running = s_r.stF & !s_r.done;
                if (s_r.stF && !s_r.done) begin
                    if (setValue == '0) begin
                        s_nxt.done = 1'b1;
                    end else if (s_r.tick && !s_r.gtF) begin
                        s_nxt.cnt = cntInc;
                        s_nxt.done = expired;
                    end
                end
                s_nxt.out = s_nxt.done;
            end
            MD_OFFDLY2: begin
                if (s_r.stF) begin
                    s_nxt.out = 1'b0;
                    s_nxt.running = 1'b0;
                    s_nxt.cnt = '0;
                end else if (stFall && setValue != '0) begin
                    s_nxt.running = 1'b1;
                    s_nxt.out = 1'b1;
                end else if (s_r.running && s_r.tick && !s_r.gtF) begin
                    s_nxt.cnt = cntInc;
                    if (expired) begin
                        s_nxt.running = 1'b0;
                        s_nxt.out = 1'b0;
                        s_nxt.cnt = '0;
                    end
                end
            end
            MD_DUTYFLK: begin
                if (stRise && !s_r.running) begin
                    s_nxt.running = 1'b1;
                    s_nxt.phase = 1'b0;
                    s_nxt.out = 1'b1;
                    s_nxt.cnt = '0;
                end else if (s_r.running && s_r.tick && !s_r.gtF) begin
                    s_nxt.cnt = cntInc;
                    if (expired) begin
                        s_nxt.cnt = '0;
                        s_nxt.phase = !s_r.phase;
                        s_nxt.out = s_r.phase;
                    end
                end
            end
            MD_STOPWATCH: begin
                latchMode = 1'b1;
                swClr = s_r.rsF | s_r.gtF;
                if (stRise) begin
                    s_nxt.swRun = !s_r.swRun;
                    if (setValue == '0) begin
                        s_nxt.done = 1'b1;
                    end
                end
                if (s_r.swRun && s_r.tick) begin
                    s_nxt.cnt = cntInc;
                    if (expired) begin
                        s_nxt.done = 1'b1;
                    end
                end
                if (!s_r.swRun && swClr) begin
                    s_nxt.cnt = '0;
                    s_nxt.done = 1'b0;
                    s_nxt.swRun = 1'b0;
                end
                s_nxt.running = s_nxt.swRun;
            end
        endcase

        shotEn = oneShot && shotTime != '0;
        if (latchMode) begin
            if (s_nxt.done && !s_r.done) begin
                s_nxt.shotOn = 1'b1;
                s_nxt.shot = '0;
            end else if (s_r.shotOn && shotTick) begin
                s_nxt.shot = s_r.shot + SHOT_W'(1);
                s_nxt.shotOn = s_r.shot + SHOT_W'(1) < shotTime;
            end
            s_nxt.out = s_nxt.done & (!shotEn | s_nxt.shotOn);
        end
        // External reset; stopwatch uses it as freeze/clear instead
        if (s_r.rsF && mode != MD_STOPWATCH) begin
            s_nxt.running = 1'b0;
            s_nxt.done = 1'b0;
            s_nxt.out = 1'b0;
            s_nxt.phase = 1'b0;
            s_nxt.shotOn = 1'b0;
            s_nxt.cnt = '0;
            s_nxt.stPrev = 1'b0;
        end
        if (!(mode == MD_STOPWATCH && s_r.swRun && swClr)) begin
            s_nxt.disp = s_nxt.cnt;
        end

        // stPrev low so held start counts as rising
        rstVal = STATE_RESET;
        rstVal.cnt = (mode == MD_PWRON2) ? s_r.cnt : '0;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_r <= rstVal;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ctlOut = s_r.out;
    assign presentValue = s_r.cnt;
    assign displayValue = s_r.disp;
    assign timingActive = s_r.running;
endmodule : mmot_timer

// *** tb/mmot_switch_model.sv ***
// Switch and sensor side of the timer: start, reset and gate contacts.
// Assumes requests change just after ref_clk edges; slow mimics laggy contacts.
`timescale 1ns/1ns
module mmot_switch_model
    import mmot_pkg::*;
#(
    parameter int HOLD_CYC = 6
) (
    input wire logic ref_clk,
    input wire logic startReq,
    input wire logic resetReq,
    input wire logic gateReq,
    input wire logic slow,
    output logic startIn,
    output logic resetIn,
    output logic gateIn
);
    logic [2:0] stLag = '0;
    logic [2:0] gtLag = '0;
    int holdCnt = 0;

    // Slow contacts close three cycles late
    always_ff @(posedge ref_clk) begin
        stLag <= {stLag[1:0], startReq};
        gtLag <= {gtLag[1:0], gateReq};
    end
    assign startIn = slow ? stLag[2] : startReq;
    assign gateIn = slow ? gtLag[2] : gateReq;

    always_ff @(posedge ref_clk) begin
        holdCnt <= resetReq ? HOLD_CYC : (holdCnt > 0 ? holdCnt - 1 : 0);
    end
    assign resetIn = resetReq || (holdCnt > 0);
endmodule : mmot_switch_model

// *** tb/mmot_timer_assertions.sv ***
// Port checker of the multi-mode output timer.
// Assumes mode and set values only change while rst is high.
`timescale 1ns/1ns
module mmot_timer_assertions
    import mmot_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic startIn,
    input wire logic resetIn,
    input wire logic gateIn,
    input wire mmot_mode_t mode,
    input wire logic [COUNT_W-1:0] setValue,
    input wire logic oneShot,
    input wire logic ctlOut,
    input wire logic [COUNT_W-1:0] presentValue,
    input wire logic [COUNT_W-1:0] displayValue,
    input wire logic timingActive
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    AST_ZERO_OFF: assert property ((mode inside {MD_ONOFF1, MD_INTERVAL, MD_OFFDLY2} && setValue == '0) |-> !ctlOut)
        else $error("output on with zero set");
    AST_ZERO_FOLLOW: assert property ((mode == MD_OFFDLY1 && setValue == '0 && !resetIn && $stable(startIn))[*8]
        |-> ctlOut == startIn) else $error("output does not follow start");
    AST_OFFDLY_ON: assert property ((mode == MD_OFFDLY1 && startIn && !resetIn)[*8] |-> ctlOut)
        else $error("output off while start held");
    AST_OFFDLY2_OFF: assert property ((mode == MD_OFFDLY2 && startIn)[*8] |-> !ctlOut)
        else $error("output on while start held");
    AST_ZERO_NOW: assert property ((mode == MD_ONDLY1 && setValue == '0 && !oneShot && !resetIn && $rose(startIn))
        ##1 startIn[*5] |-> ##[0:4] ctlOut) else $error("zero set output late");
    AST_IGNORE_START: assert property ((mode == MD_ONDLY1 && !resetIn)[*6] ##0 timingActive
        |=> presentValue >= $past(presentValue)) else $error("count restarted while timing");
    AST_DROP_CLEAR: assert property ((mode == MD_ONDLY2 && $fell(startIn)) ##1 (!startIn && !resetIn)[*8]
        |-> !ctlOut && presentValue == '0) else $error("start drop did not clear");
    AST_ACCUM_HOLD: assert property ((mode == MD_ACCUM && !startIn && !resetIn)[*8] |=> $stable(presentValue))
        else $error("paused count moved");
    AST_SW_FREEZE: assert property ((mode == MD_STOPWATCH && timingActive && gateIn)[*8] |=> $stable(displayValue))
        else $error("display not frozen");
endmodule : mmot_timer_assertions

bind mmot_timer mmot_timer_assertions i_mmot_timer_assertions (.ref_clk(ref_clk), .rst(rst), .startIn(startIn),
    .resetIn(resetIn), .gateIn(gateIn), .mode(mode), .setValue(setValue), .oneShot(oneShot), .ctlOut(ctlOut),
    .presentValue(presentValue), .displayValue(displayValue), .timingActive(timingActive));

// *** tb/mmot_timer_tb.sv ***
// Self-checking bench of the multi-mode output timer.
// Assumes the switch model in front of the pins; config changes under rst, except oneShot cleared after the one-shot test.
`timescale 1ns/1ns
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module mmot_timer_tb;
    import mmot_pkg::*;
    logic ref_clk;
    logic rst = 1'b1, startReq = 1'b0, resetReq = 1'b0, gateReq = 1'b0, slow = 1'b0, oneShot = 1'b0;
    logic startIn, resetIn, gateIn, ctlOut, timingActive;
    mmot_mode_t mode = MD_ONDLY1;
    logic [COUNT_W-1:0] setValue = '0, cycleTime = '0, presentValue, displayValue;
    logic [DUTY_W-1:0] dutyPct = '0;
    logic [SHOT_W-1:0] shotTime = '0;
    logic [31:0] tickCycles = 32'h1, seed = 32'h3407;
    int failures = 0, n_checks = 0;
    mmot_mode_t zm[8] = '{MD_ONDLY1, MD_ONDLY2, MD_ACCUM, MD_OFFDLY1, MD_ONOFF2, MD_ONOFF1, MD_INTERVAL, MD_OFFDLY2};
    logic [1:0] zx[8] = '{2'h3, 2'h2, 2'h3, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0};

    mmot_timer #(.SHOT_TICK_CYC(4)) i_mmot_timer (.ref_clk(ref_clk), .rst(rst), .startIn(startIn),
        .resetIn(resetIn), .gateIn(gateIn), .mode(mode), .setValue(setValue), .cycleTime(cycleTime),
        .dutyPct(dutyPct), .oneShot(oneShot), .shotTime(shotTime), .tickCycles(tickCycles), .ctlOut(ctlOut),
        .presentValue(presentValue), .displayValue(displayValue), .timingActive(timingActive));
    mmot_switch_model i_mmot_switch_model (.ref_clk(ref_clk), .startReq(startReq), .resetReq(resetReq),
        .gateReq(gateReq), .slow(slow), .startIn(startIn), .resetIn(resetIn), .gateIn(gateIn));

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic int onTime(input int c, input int d);
        return (c * d + 50) / 100;
    endfunction : onTime
    task automatic rnd(output int v, input int lo, input int span);
        seed = lfsr(seed);
        v = lo + int'(seed % span);
    endtask : rnd
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic setup(input mmot_mode_t m, input int s, input logic st, input int h);
        rst <= 1'b1;
        mode <= m;
        setValue <= COUNT_W'(s);
        startReq <= st;
        seed = lfsr(seed);
        slow <= seed[0];
        cyc(h);
        rst <= 1'b0;
    endtask : setup
    // Short enough to end before the output can react
    task automatic pulse();
        startReq <= 1'b1;
        cyc(3);
        startReq <= 1'b0;
    endtask : pulse
    task automatic waitOut(input logic lv, output int k);
        k = 0;
        while (ctlOut !== lv && k < 3000) begin
            cyc(1);
            k++;
        end
        if (k >= 3000) failures++;
    endtask : waitOut
    task automatic meas(input logic lv, output int n);
        n = 0;
        while (ctlOut === lv && n < 3000) begin
            cyc(1);
            n++;
        end
        if (n >= 3000) failures++;
    endtask : meas
    task automatic nudgeReset();
        resetReq <= 1'b1;
        cyc(2);
        resetReq <= 1'b0;
        cyc(12);
    endtask : nudgeReset
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test

    initial begin
        cyc(20000);
        failures++;
        end_of_test();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        int w, k, s, t, dp, on, cyT, d0;
        setup(MD_ONDLY1, 3, 1'b1, 12);
        waitOut(1'b1, k);
        `CHK(ctlOut, 1'b1)
        startReq <= 1'b0;
        cyc(30);
        `CHK(ctlOut, 1'b1)
        nudgeReset();
        `CHK(ctlOut, 1'b0)
        oneShot <= 1'b1;
        shotTime <= SHOT_W'(3);
        setup(MD_ONDLY1, 2, 1'b0, 4);
        pulse();
        waitOut(1'b1, k);
        meas(1'b1, w);
        `CHK(w >= 8 && w <= 12, 1'b1)
        oneShot <= 1'b0;
        $display("test sustained and one-shot finished");
        for (int j = 0; j < 2; j++) begin
            setup(MD_ONDLY1, 40, 1'b0, 4);
            pulse();
            if (j == 1) begin
                cyc(4);
                pulse();
            end
            waitOut(1'b1, k);
            if (j == 0) d0 = k - 7 - 3 * int'(slow);
            else `CHK(k - 3 * int'(slow), d0)
        end
        for (int j = 0; j < 3; j++) begin
            rnd(s, 1, 16);
            setup(MD_INTERVAL, s, 1'b0, 4);
            pulse();
            waitOut(1'b1, k);
            meas(1'b1, w);
            `CHK(w, s)
        end
        rnd(s, 2, 10);
        setup(MD_SHOTFLK, s, 1'b0, 4);
        pulse();
        waitOut(1'b1, k);
        meas(1'b1, w);
        `CHK(w, s)
        cyc(2 * s);
        `CHK(ctlOut, 1'b0)
        $display("test delay, interval and flicker finished");
        foreach (zm[i]) begin
            setup(zm[i], 0, 1'b0, 4);
            startReq <= 1'b1;
            cyc(12);
            `CHK(ctlOut, zx[i][1])
            startReq <= 1'b0;
            cyc(12);
            `CHK(ctlOut, zx[i][0])
        end
        setup(MD_OFFDLY1, 20, 1'b0, 4);
        pulse();
        cyc(10);
        `CHK(ctlOut, 1'b1)
        pulse();
        waitOut(1'b0, k);
        `CHK(k, 6 + 20 + 3 * int'(slow))
        $display("test zero set finished");
        setup(MD_PWRON1, 20, 1'b1, 4);
        cyc(40);
        `CHK(ctlOut, 1'b0)
        startReq <= 1'b0;
        waitOut(1'b1, k);
        `CHK(ctlOut, 1'b1)
        setup(MD_PWRON2, 200, 1'b0, 4);
        cyc(60);
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(1);
        `CHK(presentValue != '0, 1'b1)
        setup(MD_ACCUM, 30, 1'b0, 4);
        startReq <= 1'b1;
        cyc(15);
        startReq <= 1'b0;
        cyc(40);
        `CHK(ctlOut, 1'b0)
        startReq <= 1'b1;
        waitOut(1'b1, k);
        `CHK(k < 28, 1'b1)
        startReq <= 1'b0;
        cyc(12);
        `CHK(ctlOut, 1'b1)
        $display("test power-on and accumulate finished");
        setup(MD_STOPWATCH, 1000, 1'b0, 4);
        pulse();
        cyc(8);
        `CHK(timingActive, 1'b1)
        gateReq <= 1'b1;
        cyc(8);
        w = displayValue;
        cyc(4);
        `CHK(displayValue, w)
        `CHK(presentValue > displayValue, 1'b1)
        gateReq <= 1'b0;
        pulse();
        cyc(8);
        `CHK(timingActive, 1'b0)
        nudgeReset();
        `CHK(presentValue, '0)
        $display("test stopwatch finished");
        rnd(cyT, 10, 20);
        for (int j = 0; j < 3; j++) begin
            rnd(t, 1, 3);
            rnd(dp, 10, 81);
            tickCycles <= 32'(t);
            cycleTime <= COUNT_W'(cyT);
            dutyPct <= DUTY_W'(dp);
            setup(MD_DUTYFLK, 0, 1'b0, 4);
            pulse();
            waitOut(1'b1, k);
            meas(1'b1, w);
            meas(1'b0, w);
            on = onTime(cyT, dp);
            `CHK(w, (cyT - on) * t)
            meas(1'b1, w);
            `CHK(w, on * t)
        end
        $display("test duty flicker finished");
        end_of_test();
    end
endmodule : mmot_timer_tb
